// *** test/backplane_master.sv ***
// Backplane master model that reads records and fetches alarms
`timescale 1ns/1ps

module backplane_master
import cid_pkg::*;
(
    input wire logic i_clk,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid,
    input wire logic i_rd_error,
    output logic o_rd,
    output cid_pkg::access_kind_t o_rd_kind,
    output logic [15:0] o_rd_key,
    output logic [7:0] o_rd_byte,
    output logic [1:0] o_rd_lane,
    output logic o_proc_ack,
    output logic o_diag_ack
);
    ////////////////////////////////////////
    // Idle request lines at time zero
    initial
    begin
        o_rd = 1'b0;
        o_rd_kind = ACC_RECORD;
        o_rd_key = 16'h0000;
        o_rd_byte = 8'h00;
        o_rd_lane = 2'h0;
        o_proc_ack = 1'b0;
        o_diag_ack = 1'b0;
    end

    ////////////////////////////////////////
    // One read, taken at one edge, answer picked up when valid shows
    task automatic read(input access_kind_t k, input logic [15:0] key,
        input logic [7:0] b, output logic [7:0] d, output logic e,
        output logic ok);
        int n;
        n = 0;
        o_rd = 1'b1;
        o_rd_kind = k;
        o_rd_key = key;
        o_rd_byte = b;
        @(posedge i_clk);
        #1;
        o_rd = 1'b0;
        // Released lines show the inverse, never the old value
        o_rd_kind = access_kind_t'(~o_rd_kind);
        o_rd_key = ~o_rd_key;
        o_rd_byte = ~o_rd_byte;
        o_rd_lane = ~o_rd_lane;
        while (i_rd_valid !== 1'b1 && n < 3)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        ok = (i_rd_valid === 1'b1);
        d = i_rd_data;
        e = i_rd_error;
        @(posedge i_clk);
        #1;
    endtask

    // One-cycle fetch pulse for a process or a diagnostic alarm
    task automatic ack(input logic diag);
        if (diag)
            o_diag_ack = 1'b1;
        else
            o_proc_ack = 1'b1;
        @(posedge i_clk);
        #1;
        if (diag)
            o_diag_ack = 1'b0;
        else
            o_proc_ack = 1'b0;
    endtask
endmodule

// *** test/counter_interrupt_diagnostics_bench.sv ***
// Self-checking bench of the counter interrupt and diagnostic block
`timescale 1ns/1ps

module counter_interrupt_diagnostics_bench;
    import cid_pkg::*;

    // Ordinary read: request beside its expected answer
    typedef struct packed
    {
        access_kind_t k;
        logic [15:0] key;
        logic [7:0] b;
        logic [7:0] d;
        logic e;
    } row_t;

    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic pen = 1'b1;
    logic den = 1'b1;
    logic [3:0] een = 4'hf;
    logic [1:0] ovf = 2'h0;
    logic [1:0] und = 2'h0;
    logic [1:0] endv = 2'h0;
    logic [1:0] cmp = 2'h0;
    logic [1:0] pha = 2'h0;
    logic [1:0] phb = 2'h0;
    logic overload = 1'b0;
    logic canopen = 1'b0;
    logic ce = 1'b1;
    logic rd, pack, dack, valid, err;
    logic alarm, emcy, dtel, inc, going, fault;
    access_kind_t kind;
    logic [15:0] key;
    logic [7:0] rbyte, data;
    logic [1:0] lane;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    int rel = 0;
    row_t rows [15];

    ////////////////////////////////////////
    // Clock and cycle count
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;

    counter_interrupt_diagnostics DUT (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_ce(ce), .i_proc_irq_enable(pen), .i_diag_irq_enable(den),
        .i_evt_enable(een), .i_evt_overflow(ovf), .i_evt_underflow(und),
        .i_evt_end_value(endv), .i_evt_compare(cmp),
        .i_encoder_phase_a(pha), .i_encoder_phase_b(phb),
        .i_supply_overload(overload), .i_bus_canopen(canopen),
        .i_proc_ack(pack), .i_diag_ack(dack), .i_rd(rd),
        .i_rd_kind(kind), .i_rd_key(key), .i_rd_byte(rbyte),
        .i_rd_lane(lane), .o_rd_data(data), .o_rd_valid(valid),
        .o_rd_error(err), .o_proc_alarm(alarm), .o_proc_emcy_tel(emcy),
        .o_proc_diag_tel(dtel), .o_diag_incoming(inc),
        .o_diag_going(going), .o_module_fault_indicator(fault));

    backplane_master master (.i_clk(i_clk), .i_rd_data(data),
        .i_rd_valid(valid), .i_rd_error(err), .o_rd(rd),
        .o_rd_kind(kind), .o_rd_key(key), .o_rd_byte(rbyte),
        .o_rd_lane(lane), .o_proc_ack(pack), .o_diag_ack(dack));

    ////////////////////////////////////////
    // Shared tasks
    task automatic tick();
        @(posedge i_clk);
        #1;
    endtask

    task automatic complete_run();
        $display("Counts: %0d compares, %0d mismatches", compares,
            fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_read(input access_kind_t k, input logic [15:0] a,
        input logic [7:0] b, input logic [7:0] d, input logic e);
        logic [7:0] got;
        logic gerr;
        logic ok;
        master.read(k, a, b, got, gerr, ok);
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("Error at %0t: read not answered", $time);
            complete_run();
        end
        check_byte(got, d);
        check_byte({7'h00, gerr}, {7'h00, e});
    endtask

    // One-cycle event pulses
    task automatic pulse(input logic [1:0] o, u, n, c);
        ovf = o;
        und = u;
        endv = n;
        cmp = c;
        tick();
        ovf = 2'h0;
        und = 2'h0;
        endv = 2'h0;
        cmp = 2'h0;
    endtask

    task automatic do_reset();
        i_nrst = 1'b0;
        repeat (10) tick();
        check_byte({valid, err, alarm, emcy, dtel, inc, going, fault}, 8'h00);
        i_nrst = 1'b1;
        rel = cyc;
        $display("test reset done");
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial
    begin
        rows = '{
            '{ACC_RECORD, 16'h0001, 8'h01, 8'h18, 1'b0},
            '{ACC_RECORD, 16'h0001, 8'h04, 8'h76, 1'b0},
            '{ACC_RECORD, 16'h0001, 8'h05, 8'h08, 1'b0},
            '{ACC_RECORD, 16'h0001, 8'h06, 8'h02, 1'b0},
            '{ACC_RECORD, 16'h0001, 8'h02, 8'h00, 1'b0},
            '{ACC_RECORD, 16'h0001, 8'h0c, 8'h00, 1'b0},
            '{ACC_RECORD, 16'h0001, 8'h15, 8'h00, 1'b1},
            '{ACC_RECORD, 16'h0000, 8'h00, 8'h00, 1'b0},
            '{ACC_RECORD, 16'h0000, 8'h04, 8'h00, 1'b1},
            '{ACC_CANOPEN, 16'h2f01, 8'h01, 8'h18, 1'b0},
            '{ACC_CANOPEN, 16'h2f00, 8'h04, 8'h00, 1'b1},
            '{ACC_CANOPEN, 16'h2f01, 8'h04, 8'h76, 1'b0},
            '{ACC_ETHERCAT, 16'h5005, 8'h03, 8'h18, 1'b0},
            '{ACC_ETHERCAT, 16'h5005, 8'h06, 8'h76, 1'b0},
            '{ACC_ETHERCAT, 16'h1234, 8'h02, 8'h00, 1'b1}};
        do_reset();
        foreach (rows[i])
            check_read(rows[i].k, rows[i].key, rows[i].b, rows[i].d,
                rows[i].e);
        $display("test rows done");
        do_reset();
        // Timestamps 500 cycles apart, first before the first tick
        while (cyc < rel + 49) tick();
        pha = 2'b01;
        phb = 2'b10;
        pulse(2'b01, 2'h0, 2'h0, 2'h0);
        check_byte({7'h00, alarm}, 8'h01);
        check_byte({6'h00, emcy, dtel}, 8'h01);
        check_read(ACC_ETHERCAT, OBJ_PROC, 8'h02, 8'h04, 1'b0);
        check_read(ACC_ETHERCAT, OBJ_PROC, 8'h03, 8'h09, 1'b0);
        check_read(ACC_ETHERCAT, OBJ_PROC, 8'h04, 8'h00, 1'b0);
        master.ack(1'b0);
        check_byte({7'h00, alarm}, 8'h00);
        while (cyc < rel + 549) tick();
        pha = 2'b10;
        phb = 2'b01;
        pulse(2'b01, 2'h0, 2'h0, 2'b10);
        check_read(ACC_ETHERCAT, OBJ_PROC, 8'h04, 8'h05, 1'b0);
        check_read(ACC_ETHERCAT, OBJ_PROC, 8'h02, 8'h84, 1'b0);
        check_read(ACC_ETHERCAT, OBJ_PROC, 8'h03, 8'h06, 1'b0);
        $display("test process record done");
        // Second event on a pending channel is lost
        pulse(2'b11, 2'h0, 2'h0, 2'h0);
        tick();
        check_byte({6'h00, inc, fault}, 8'h03);
        check_read(ACC_RECORD, REC_FULL, 8'h00, 8'h0b, 1'b0);
        check_read(ACC_RECORD, REC_FULL, 8'h03, 8'h40, 1'b0);
        check_read(ACC_RECORD, REC_FULL, 8'h07, 8'h03, 1'b0);
        check_read(ACC_RECORD, REC_FULL, 8'h08, 8'h04, 1'b0);
        pulse(2'h0, 2'h0, 2'h0, 2'b01);
        check_read(ACC_RECORD, REC_FULL, 8'h08, 8'h04, 1'b0);
        master.ack(1'b0);
        master.ack(1'b1);
        tick();
        check_byte({6'h00, going, fault}, 8'h02);
        $display("test lost alarm done");
        // Gated sources, then a telegram in the other bus mode
        pen = 1'b0;
        pulse(2'h0, 2'b10, 2'h0, 2'h0);
        check_byte({7'h00, alarm}, 8'h00);
        tick();
        pen = 1'b1;
        een = 4'b1101;
        pulse(2'h0, 2'b10, 2'h0, 2'h0);
        check_byte({7'h00, alarm}, 8'h00);
        tick();
        een = 4'hf;
        canopen = 1'b1;
        pulse(2'h0, 2'h0, 2'b10, 2'h0);
        check_byte({6'h00, emcy, dtel}, 8'h02);
        check_read(ACC_ETHERCAT, OBJ_PROC, 8'h02, 8'h40, 1'b0);
        master.ack(1'b0);
        $display("test enables done");
        // Supply overload comes and goes
        overload = 1'b1;
        tick();
        check_byte({7'h00, inc}, 8'h01);
        check_read(ACC_RECORD, REC_SHORT, 8'h00, 8'h05, 1'b0);
        overload = 1'b0;
        tick();
        check_byte({7'h00, going}, 8'h01);
        // Unfetched alarms pile up past sixteen
        repeat (8)
        begin
            overload = 1'b1;
            repeat (2) tick();
            overload = 1'b0;
            repeat (2) tick();
        end
        check_read(ACC_RECORD, REC_FULL, 8'h03, 8'h08, 1'b0);
        check_byte({7'h00, fault}, 8'h01);
        // Clock enable low freezes event capture
        ce = 1'b0;
        pulse(2'b01, 2'h0, 2'h0, 2'h0);
        check_byte({7'h00, alarm}, 8'h00);
        ce = 1'b1;
        $display("test diagnostics done");
        complete_run();
    end
endmodule

// *** verilog/cid_pkg.sv ***
// Shared constants and types of the counter interrupt and diagnostic block
package cid_pkg;

    // Access path chosen by the backplane master
    typedef enum logic [1:0] {ACC_RECORD, ACC_CANOPEN, ACC_ETHERCAT} access_kind_t;

    // Microsecond ticker timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);

    // Record set numbers and object indices
    localparam logic [15:0] REC_SHORT = 16'h0000;
    localparam logic [15:0] REC_FULL = 16'h0001;
    localparam logic [15:0] IDX_SHORT = 16'h2f00;
    localparam logic [15:0] IDX_FULL = 16'h2f01;
    localparam logic [15:0] OBJ_DIAG = 16'h5005;
    localparam logic [15:0] OBJ_PROC = 16'h5000;

    // Record geometry
    localparam logic [4:0] SHORT_LEN = 5'h04;
    localparam logic [4:0] DIAG_LEN = 5'h15;
    localparam logic [4:0] PROC_LEN = 5'h04;
    localparam logic [7:0] SUB_FIRST = 8'h02;
    localparam logic [7:0] SUB_DIAG_TS = 8'h13;
    localparam logic [7:0] SUB_PROC_LAST = 8'h05;

    // Byte offsets of the diagnostic record
    localparam logic [4:0] OFS_SUMMARY = 5'h00;
    localparam logic [4:0] OFS_MODCLASS = 5'h01;
    localparam logic [4:0] OFS_OVF_LOST = 5'h03;
    localparam logic [4:0] OFS_CHKIND = 5'h04;
    localparam logic [4:0] OFS_BITS = 5'h05;
    localparam logic [4:0] OFS_CHCOUNT = 5'h06;
    localparam logic [4:0] OFS_GROUPS = 5'h07;
    localparam logic [4:0] OFS_CH0 = 5'h08;
    localparam logic [4:0] OFS_CH1 = 5'h09;
    localparam logic [4:0] OFS_DIAG_TS = 5'h11;

    // Fixed identification bytes
    localparam logic [7:0] MODULE_CLASS_INFO = 8'h18;
    localparam logic [7:0] CHANNEL_KIND = 8'h76;
    localparam logic [7:0] DIAG_BITS_PER_CH = 8'h08;
    localparam logic [7:0] CHANNEL_COUNT = 8'h02;

    // Field positions
    localparam int BIT_LIMIT = 2;
    localparam int BIT_COMPARE = 3;
    localparam int BIT_BUF_OVF = 3;
    localparam int BIT_PROC_LOST = 6;
    localparam int CH1_SHIFT = 4;
    localparam logic [4:0] DIAG_PENDING_MAX = 5'h10;

endpackage

// *** verilog/counter_interrupt_diagnostics.sv ***
// Process interrupt and diagnostic records of a two-channel counter module
`timescale 1ns/1ps

// Behaviour
// R1: Enabled counter events raise a process interrupt
// R2: Flag byte bits 2,3 counter0; 6,7 counter1
// R3: Latch four encoder input levels per interrupt
// R4: Process record captures 16-bit microsecond timestamp
// R5: Microsecond ticker starts at zero and wraps
// R6: Diagnostic record captures 32-bit timestamp
// R7: Enabled incoming diagnostic for overflow, lost interrupt
// R8: Going diagnostic once the cause disappears
// R9: Channel events discarded inside diagnostic window
// R10: Fault indicator on throughout diagnostic window
// R11: Summary byte: module, internal, external, channel
// R12: Bit 3 flags over sixteen pending alarms
// R13: One pending alarm per channel; extra sets bit6
// R14: Module class byte reads 18h
// R15: Channel kind byte reads 76h
// R16: Eight bits per channel, two channels
// R17: Group error bits per counter channel
// R18: Per-counter lost bits 2 and 3
// R19: Record set 01h full, 00h first four
// R20: Index 2F01h full, 2F00h first four
// R21: Objects 5005h and 5000h by subindex
// R22: Emergency telegram on CANopen, else diagnostics
// R23: Reserved bits and bytes read zero
module counter_interrupt_diagnostics
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_proc_irq_enable,
    input wire logic i_diag_irq_enable,
    input wire logic [3:0] i_evt_enable,
    input wire logic [1:0] i_evt_overflow,
    input wire logic [1:0] i_evt_underflow,
    input wire logic [1:0] i_evt_end_value,
    input wire logic [1:0] i_evt_compare,
    input wire logic [1:0] i_encoder_phase_a,
    input wire logic [1:0] i_encoder_phase_b,
    input wire logic i_supply_overload,
    input wire logic i_bus_canopen,
    input wire logic i_proc_ack,
    input wire logic i_diag_ack,
    input wire logic i_rd,
    input wire cid_pkg::access_kind_t i_rd_kind,
    input wire logic [15:0] i_rd_key,
    input wire logic [7:0] i_rd_byte,
    input wire logic [1:0] i_rd_lane,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_rd_error,
    output logic o_proc_alarm,
    output logic o_proc_emcy_tel,
    output logic o_proc_diag_tel,
    output logic o_diag_incoming,
    output logic o_diag_going,
    output logic o_module_fault_indicator
);
    import cid_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Microsecond ticker
    logic [6:0] tick_div_q;
    logic [31:0] ticker_q;

    // Prescaler divides the clock down to one microsecond
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            tick_div_q <= 7'h00;
            ticker_q <= 32'h0000_0000; // R5
        end
        else if (i_ce)
        begin
            if (tick_div_q == TICK_LAST)
            begin
                tick_div_q <= 7'h00;
                ticker_q <= ticker_q + 32'h0000_0001; // R5
            end
            else
            begin
                tick_div_q <= tick_div_q + 7'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Process events per channel
    logic [1:0] lim_hit;
    logic [1:0] cmp_hit;
    logic [1:0] any_hit;
    logic [1:0] ch_pend_q;
    logic [1:0] ch_pend_d;
    logic [1:0] lim_lost_q;
    logic [1:0] cmp_lost_q;
    logic [1:0] ch_lost;
    logic [1:0] accept;
    logic [1:0] collide;
    logic [7:0] proc_flags_q;
    logic [7:0] input_snap_q;
    logic [15:0] proc_ts_q;

    // Enable order: overflow, underflow, compare, end value
    assign lim_hit = ({2{i_proc_irq_enable}} &
        (({2{i_evt_enable[0]}} & i_evt_overflow) |
         ({2{i_evt_enable[1]}} & i_evt_underflow) |
         ({2{i_evt_enable[3]}} & i_evt_end_value))); // R1
    assign cmp_hit = {2{i_proc_irq_enable & i_evt_enable[2]}} &
        i_evt_compare; // R1
    assign any_hit = lim_hit | cmp_hit;
    assign ch_lost = lim_lost_q | cmp_lost_q;
    // Window open on a channel swallows its events entirely
    assign accept = any_hit & ~ch_pend_q & ~ch_lost; // R9
    assign collide = any_hit & ch_pend_q & ~ch_lost; // R9 R13

    // Pending flag per channel, a new alarm wins over the acknowledge
    always_comb
    begin
        ch_pend_d = ch_pend_q;
        if (i_proc_ack)
        begin
            ch_pend_d = 2'b00;
        end
        ch_pend_d = ch_pend_d | accept; // R13
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            ch_pend_q <= 2'b00;
        end
        else if (i_ce)
        begin
            ch_pend_q <= ch_pend_d;
        end
    end

    // Process record: flags, input levels and short timestamp
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            proc_flags_q <= 8'h00;
            input_snap_q <= 8'h00;
            proc_ts_q <= 16'h0000;
        end
        else if (i_ce)
        begin
            if (|accept)
            begin
                proc_flags_q <= (i_proc_ack ? 8'h00 : proc_flags_q) |
                    {accept[1] & cmp_hit[1], accept[1] & lim_hit[1],
                     2'b00,
                     accept[0] & cmp_hit[0], accept[0] & lim_hit[0],
                     2'b00}; // R2 R23
                input_snap_q <= {4'h0, i_encoder_phase_b[1],
                    i_encoder_phase_a[1], i_encoder_phase_b[0],
                    i_encoder_phase_a[0]}; // R3 R23
                proc_ts_q <= ticker_q[15:0]; // R4 R5
            end
            else if (i_proc_ack)
            begin
                proc_flags_q <= 8'h00;
            end
        end
    end

    // Telegram kind follows the backplane protocol
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_proc_alarm <= 1'b0;
            o_proc_emcy_tel <= 1'b0;
            o_proc_diag_tel <= 1'b0;
        end
        else if (i_ce)
        begin
            o_proc_alarm <= |ch_pend_d;
            o_proc_emcy_tel <= (|accept) & i_bus_canopen; // R22
            o_proc_diag_tel <= (|accept) & ~i_bus_canopen; // R22
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lost process interrupts, held until the diagnostic is acknowledged
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            lim_lost_q <= 2'b00;
            cmp_lost_q <= 2'b00;
        end
        else if (i_ce)
        begin
            lim_lost_q <= (i_diag_ack ? 2'b00 : lim_lost_q) |
                (collide & lim_hit); // R13 R18
            cmp_lost_q <= (i_diag_ack ? 2'b00 : cmp_lost_q) |
                (collide & cmp_hit); // R13 R18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Diagnostic alarm window
    logic [4:0] diag_cnt_q;
    logic buf_ovf;
    logic diag_cause;
    logic diag_active_q;
    logic diag_in;
    logic diag_out;
    logic [31:0] diag_ts_q;

    assign buf_ovf = diag_cnt_q > DIAG_PENDING_MAX; // R12
    assign diag_cause = i_diag_irq_enable & ((|ch_lost) | buf_ovf |
        i_supply_overload); // R7
    assign diag_in = diag_cause & ~diag_active_q; // R7
    assign diag_out = ~diag_cause & diag_active_q; // R8

    // Window state and captured long timestamp
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            diag_active_q <= 1'b0;
            diag_ts_q <= 32'h0000_0000;
        end
        else if (i_ce)
        begin
            diag_active_q <= diag_cause;
            if (diag_in)
            begin
                diag_ts_q <= ticker_q; // R6
            end
        end
    end

    // Count of alarms not yet fetched by the master, saturating
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            diag_cnt_q <= 5'h00;
        end
        else if (i_ce)
        begin
            if ((diag_in | diag_out) && !i_diag_ack)
            begin
                if (diag_cnt_q != 5'h1f)
                begin
                    diag_cnt_q <= diag_cnt_q + 5'h01; // R12
                end
            end
            else if (!(diag_in | diag_out) && i_diag_ack &&
                diag_cnt_q != 5'h00)
            begin
                diag_cnt_q <= diag_cnt_q - 5'h01;
            end
        end
    end

    // Interrupt pulses and fault indicator
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_diag_incoming <= 1'b0;
            o_diag_going <= 1'b0;
            o_module_fault_indicator <= 1'b0;
        end
        else if (i_ce)
        begin
            o_diag_incoming <= diag_in; // R7
            o_diag_going <= diag_out; // R8
            o_module_fault_indicator <= diag_cause; // R10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Record byte views
    logic [7:0] summary_byte;
    logic [7:0] ovf_lost_byte;
    logic [7:0] group_byte;
    logic [7:0] ch0_byte;
    logic [7:0] ch1_byte;

    assign summary_byte = {4'h0, |ch_lost, i_supply_overload, |ch_lost,
        (|ch_lost) | i_supply_overload}; // R11 R23
    assign ovf_lost_byte = {1'b0, |ch_lost, 2'b00, buf_ovf, 3'b000}; // R12 R13
    assign group_byte = {6'h00, ch_lost}; // R17
    assign ch0_byte = {4'h0, cmp_lost_q[0], lim_lost_q[0], 2'b00}; // R18
    assign ch1_byte = {4'h0, cmp_lost_q[1], lim_lost_q[1], 2'b00}; // R18

    // Diagnostic record byte by offset
    function automatic logic [7:0] diag_byte(input logic [4:0] ofs);
        logic [7:0] b;
        b = 8'h00; // R23
        if (ofs == OFS_SUMMARY)
            b = summary_byte;
        else if (ofs == OFS_MODCLASS)
            b = MODULE_CLASS_INFO; // R14
        else if (ofs == OFS_OVF_LOST)
            b = ovf_lost_byte;
        else if (ofs == OFS_CHKIND)
            b = CHANNEL_KIND; // R15
        else if (ofs == OFS_BITS)
            b = DIAG_BITS_PER_CH; // R16
        else if (ofs == OFS_CHCOUNT)
            b = CHANNEL_COUNT; // R16
        else if (ofs == OFS_GROUPS)
            b = group_byte;
        else if (ofs == OFS_CH0)
            b = ch0_byte;
        else if (ofs == OFS_CH1)
            b = ch1_byte;
        else if (ofs >= OFS_DIAG_TS && ofs < DIAG_LEN)
            b = 8'(diag_ts_q >> {ofs - OFS_DIAG_TS, 3'b000}); // R6
        return b;
    endfunction

    // Process record byte by offset, timestamp low byte first
    function automatic logic [7:0] proc_byte(input logic [4:0] ofs);
        logic [7:0] b;
        b = 8'h00;
        if (ofs == 5'h00)
            b = proc_flags_q;
        else if (ofs == 5'h01)
            b = input_snap_q;
        else if (ofs == 5'h02)
            b = proc_ts_q[7:0];
        else if (ofs == 5'h03)
            b = proc_ts_q[15:8];
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Read decode
    logic [7:0] sub_ofs;
    logic [4:0] ts_ofs;
    logic [7:0] rd_data_d;
    logic rd_err_d;

    assign sub_ofs = i_rd_byte - SUB_FIRST;
    assign ts_ofs = OFS_DIAG_TS + {3'b000, i_rd_lane};

    always_comb
    begin
        rd_data_d = 8'h00;
        rd_err_d = 1'b0;
        if (i_rd_kind == ACC_RECORD && i_rd_key == REC_FULL &&
            i_rd_byte < {3'b000, DIAG_LEN})
            rd_data_d = diag_byte(i_rd_byte[4:0]); // R19
        else if (i_rd_kind == ACC_RECORD && i_rd_key == REC_SHORT &&
            i_rd_byte < {3'b000, SHORT_LEN})
            rd_data_d = diag_byte(i_rd_byte[4:0]); // R19
        else if (i_rd_kind == ACC_CANOPEN && i_rd_key == IDX_FULL &&
            i_rd_byte < {3'b000, DIAG_LEN})
            rd_data_d = diag_byte(i_rd_byte[4:0]); // R20
        else if (i_rd_kind == ACC_CANOPEN && i_rd_key == IDX_SHORT &&
            i_rd_byte < {3'b000, SHORT_LEN})
            rd_data_d = diag_byte(i_rd_byte[4:0]); // R20
        else if (i_rd_kind == ACC_ETHERCAT && i_rd_key == OBJ_DIAG &&
            i_rd_byte == SUB_DIAG_TS)
            rd_data_d = diag_byte(ts_ofs); // R21
        else if (i_rd_kind == ACC_ETHERCAT && i_rd_key == OBJ_DIAG &&
            i_rd_byte >= SUB_FIRST && i_rd_byte < SUB_DIAG_TS)
            rd_data_d = diag_byte(sub_ofs[4:0]); // R21
        else if (i_rd_kind == ACC_ETHERCAT && i_rd_key == OBJ_PROC &&
            i_rd_byte >= SUB_FIRST && i_rd_byte <= SUB_PROC_LAST)
            rd_data_d = proc_byte(sub_ofs[4:0]); // R21
        else
            rd_err_d = 1'b1;
    end

    // Answer one cycle after the request
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_rd_data <= 8'h00;
            o_rd_valid <= 1'b0;
            o_rd_error <= 1'b0;
        end
        else if (i_ce)
        begin
            o_rd_valid <= i_rd;
            o_rd_error <= i_rd & rd_err_d;
            if (i_rd)
            begin
                o_rd_data <= rd_err_d ? 8'h00 : rd_data_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    property p_tick_step;
        i_ce && tick_div_q == TICK_LAST |=> ticker_q == $past(ticker_q) + 1;
    endproperty
    a_tick_step: assert property (p_tick_step) // R5
        else $error("ticker did not advance");

    property p_accept_flags;
        i_ce && accept[0] && lim_hit[0] |=> proc_flags_q[BIT_LIMIT];
    endproperty
    a_accept_flags: assert property (p_accept_flags) // R2
        else $error("limit flag of counter zero missing");

    property p_snap;
        i_ce && (|accept) |=> input_snap_q[3:0] == $past({i_encoder_phase_b[1],
            i_encoder_phase_a[1], i_encoder_phase_b[0], i_encoder_phase_a[0]});
    endproperty
    a_snap: assert property (p_snap) // R3
        else $error("input snapshot wrong");

    property p_proc_ts;
        i_ce && (|accept) |=> proc_ts_q == $past(ticker_q[15:0]);
    endproperty
    a_proc_ts: assert property (p_proc_ts) // R4
        else $error("process timestamp wrong");

    property p_diag_ts;
        i_ce && diag_in |=> diag_ts_q == $past(ticker_q) && o_diag_incoming;
    endproperty
    a_diag_ts: assert property (p_diag_ts) // R6
        else $error("diagnostic timestamp or incoming pulse wrong");

    property p_going;
        i_ce && diag_active_q && !diag_cause |=> o_diag_going && !diag_active_q;
    endproperty
    a_going: assert property (p_going) // R8
        else $error("going diagnostic missing");

    property p_discard;
        i_ce && (|(any_hit & ch_lost)) && !i_proc_ack && !(|accept)
            |=> proc_flags_q == $past(proc_flags_q);
    endproperty
    a_discard: assert property (p_discard) // R9
        else $error("event stored inside diagnostic window");

    property p_led;
        i_ce ##1 i_ce |-> o_module_fault_indicator == $past(diag_cause);
    endproperty
    a_led: assert property (p_led) // R10
        else $error("fault indicator does not follow window");

    property p_collide;
        i_ce && collide[1] && !i_diag_ack && i_diag_irq_enable
            |=> ch_lost[1] && ovf_lost_byte[BIT_PROC_LOST] && group_byte[1];
    endproperty
    a_collide: assert property (p_collide) // R13
        else $error("second alarm on channel one not flagged");

    property p_summary;
        summary_byte[3:0] == {|ch_lost, i_supply_overload, |ch_lost,
            (|ch_lost) | i_supply_overload};
    endproperty
    a_summary: assert property (p_summary) // R11
        else $error("summary byte wrong");

    property p_short_set;
        i_ce && i_rd && i_rd_kind == ACC_RECORD && i_rd_key == REC_SHORT &&
            i_rd_byte == 8'h04 |=> o_rd_valid && o_rd_error;
    endproperty
    a_short_set: assert property (p_short_set) // R19
        else $error("short record served beyond four bytes");

    property p_ident;
        diag_byte(OFS_MODCLASS) == 8'h18 && diag_byte(OFS_CHKIND) == 8'h76;
    endproperty
    a_ident: assert property (p_ident) // R14
        else $error("identification bytes wrong");

endmodule
